/* File: verilog/ahfm_pkg.sv */
/*
 package for the axis homing and fault mask block: register offsets,
 field positions, reset values, enumerations and carrier structs.
 assumes a single 25 MHz clock and synchronous active-high reset.
*/
package ahfm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned POS_W = 32;
  localparam int unsigned SPD_W = 16;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FORCE_VAL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_RECAL_VAL = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_RECAL_THR = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_AUTO_SPEED = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_MANUAL_SPEED = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_SCALE = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_POSITION = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_FAULT_WORD = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_SPEED = 8'h34;
  // ctrl fields
  localparam int unsigned CTRL_DIR_NEG = 0;
  localparam int unsigned CTRL_LONG_CAM = 1;
  localparam int unsigned CTRL_USE_ZERO = 2;
  localparam int unsigned CTRL_MANUAL = 3;
  localparam int unsigned CTRL_ROLLOVER = 4;
  localparam int unsigned CTRL_RECAL_EN = 5;
  localparam int unsigned CTRL_MASK_LSB = 8;
  localparam int unsigned CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  // command codes written to the command register
  localparam logic [4:0] CMD_AUTO_HOME = 5'h0e;
  localparam logic [4:0] CMD_MANUAL_HOME = 5'h10;
  localparam logic [4:0] CMD_AUTO_FORCE = 5'h11;
  localparam logic [4:0] CMD_MANUAL_FORCE = 5'h12;
  localparam logic [4:0] CMD_STOP = 5'h13;
  // interrupt status bits
  localparam int unsigned IRQ_HOMED = 0;
  localparam int unsigned IRQ_NO_ZERO = 1;
  localparam int unsigned IRQ_REFUSED = 2;
  localparam int unsigned IRQ_RECAL_ERR = 3;
  localparam int unsigned IRQ_FAULT = 4;
  localparam int unsigned IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
  localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
  localparam logic [SPD_W-1:0] SPD_RESET = 16'h0000;
  localparam logic [7:0] SCALE_RESET = 8'h80;
  localparam int unsigned SCALE_SHIFT = 7;
  localparam int unsigned SLOW_SHIFT = 3;
  typedef enum logic [2:0] {
    AHFM_IDLE, AHFM_APPROACH, AHFM_ON_CAM, AHFM_FIND_EXIT, AHFM_STOP
  } ahfm_state_t;
  typedef struct packed {
    logic drive_fault;
    logic encoder_supply_fault;
    logic emergency_stop_fault;
    logic aux_supply_fault;
  } ahfm_mfault_t;
  typedef struct packed {
    logic cam;
    logic zero_marker;
    logic detector;
    logic enc_up;
    logic enc_down;
  } ahfm_field_t;
endpackage : ahfm_pkg

/* File: verilog/ahfm_axis.sv */
/*
 axis homing and fault mask logic for one servo axis channel.
 assumes field inputs synchronous to clk, encoder already decoded to
 up/down count pulses, and a register port with read data one cycle later.
*/
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ahfm_axis (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ahfm_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire ahfm_pkg::ahfm_field_t field,
  input wire ahfm_pkg::ahfm_mfault_t mfault,
  input wire logic [3:0] other_fault,
  output logic [ahfm_pkg::SPD_W-1:0] speed_cmd,
  output logic move_neg,
  output logic moving,
  output logic drive_enable,
  output logic referenced,
  output logic channel_error_bit,
  output logic axis_fault_flag,
  output logic axis_ok_flag,
  output logic hw_error_flag,
  output logic irq
);
  import ahfm_pkg::*;

  // ********************************
  // registers and state
  // ********************************
  logic [CTRL_W-1:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [POS_W-1:0] force_val;
  logic [POS_W-1:0] recal_val;
  logic [POS_W-1:0] recal_thr;
  logic [SPD_W-1:0] auto_speed;
  logic [SPD_W-1:0] manual_speed;
  logic [7:0] speed_scale_coeff;
  logic [POS_W-1:0] position;
  logic [7:0] channel_fault_word;
  logic homing_manual;
  logic zero_seen;
  logic cam_q;
  logic det_q;
  ahfm_state_t state;
  ahfm_state_t next_state;

  // ********************************
  // decode
  // ********************************
  wire we_ctrl = wr && addr == OFF_CTRL;
  wire we_cmd = wr && addr == OFF_CMD;
  wire we_irq_stat = wr && addr == OFF_IRQ_STAT;
  wire [4:0] cmd_code = wdata[4:0];
  wire dir_neg = ctrl[CTRL_DIR_NEG];
  wire long_cam = ctrl[CTRL_LONG_CAM];
  wire use_zero = ctrl[CTRL_USE_ZERO];
  wire [3:0] hw_fault_mask = ctrl[CTRL_MASK_LSB +: 4];
  wire [3:0] raw_mfault = {mfault.drive_fault, mfault.encoder_supply_fault,
                           mfault.emergency_stop_fault, mfault.aux_supply_fault};
  wire [3:0] unmasked_mfault = raw_mfault & ~hw_fault_mask;
  wire [7:0] raw_fault = {raw_mfault, other_fault};
  wire [7:0] vis_fault = {unmasked_mfault, other_fault};
  wire any_raw_fault = |raw_fault;
  wire any_vis_fault = |vis_fault;

  wire is_home_cmd = we_cmd && (cmd_code == CMD_AUTO_HOME || cmd_code == CMD_MANUAL_HOME);
  wire is_force_cmd = we_cmd && (cmd_code == CMD_AUTO_FORCE || cmd_code == CMD_MANUAL_FORCE);
  wire is_stop_cmd = we_cmd && cmd_code == CMD_STOP;
  wire long_illegal = long_cam && ctrl[CTRL_ROLLOVER];
  wire home_ok = is_home_cmd && state == AHFM_IDLE && !any_raw_fault && !long_illegal;
  wire home_refused = is_home_cmd && !home_ok;
  wire cmd_manual = cmd_code == CMD_MANUAL_HOME;

  wire cam_rise = field.cam && !cam_q;
  wire cam_fall = !field.cam && cam_q;
  wire det_rise = field.detector && !det_q;

  // ********************************
  // speed selection
  // ********************************
  function automatic logic [SPD_W-1:0] scale_speed(input logic [SPD_W-1:0] base, input logic [7:0] k);
    logic [SPD_W+7:0] prod;
    prod = base * k;
    scale_speed = prod[SCALE_SHIFT +: SPD_W];
  endfunction : scale_speed

  wire [SPD_W-1:0] base_f = scale_speed(homing_manual ? manual_speed : auto_speed, speed_scale_coeff);
  wire [SPD_W-1:0] slow_f = base_f >> SLOW_SHIFT;
  // final-phase speed: short cam positive keeps F, all else F/8
  wire [SPD_W-1:0] final_f = (!long_cam && !dir_neg) ? base_f : slow_f;
  wire [SPD_W-1:0] next_speed = (state == AHFM_APPROACH) ? base_f :
                                (state == AHFM_ON_CAM || state == AHFM_FIND_EXIT) ? final_f : SPD_RESET;

  // final direction: long cam backs off the cam the opposite way
  wire next_move_neg = (state == AHFM_FIND_EXIT && long_cam) ? !dir_neg : dir_neg;

  // ********************************
  // homing sequence
  // ********************************
  // home condition: zero marker seen on a short cam or past a long cam, or cam falling edge when marker unused
  wire ref_event = (state == AHFM_ON_CAM && !long_cam && use_zero && field.zero_marker) ||
                   (state == AHFM_ON_CAM && !long_cam && !use_zero && cam_fall) ||
                   (state == AHFM_FIND_EXIT && !use_zero && cam_fall) ||
                   (state == AHFM_FIND_EXIT && use_zero && !field.cam && field.zero_marker);
  // whole short cam crossed without a marker
  wire no_zero_err = state == AHFM_ON_CAM && !long_cam && use_zero && cam_fall && !zero_seen;

  always_comb begin
    next_state = state;
    case (state)
      AHFM_IDLE: begin
        if (home_ok) begin
          next_state = field.cam ? (long_cam ? AHFM_FIND_EXIT : AHFM_ON_CAM) : AHFM_APPROACH;
        end
      end
      AHFM_APPROACH: begin
        if (cam_rise) begin
          next_state = long_cam ? AHFM_FIND_EXIT : AHFM_ON_CAM;
        end
      end
      AHFM_ON_CAM: begin
        if (ref_event || no_zero_err) begin
          next_state = AHFM_STOP;
        end
      end
      AHFM_FIND_EXIT: begin
        if (ref_event) begin
          next_state = AHFM_STOP;
        end
      end
      AHFM_STOP: next_state = AHFM_IDLE;
      default: next_state = AHFM_IDLE;
    endcase
    if (any_raw_fault || is_stop_cmd) begin
      next_state = AHFM_IDLE;
    end
  end

  // ********************************
  // position and recalibration
  // ********************************
  wire [POS_W-1:0] counted = field.enc_up && !field.enc_down ? position + 32'h1 :
                             field.enc_down && !field.enc_up ? position - 32'h1 : position;
  wire recal_hit = ctrl[CTRL_RECAL_EN] && referenced && det_rise;
  wire [POS_W-1:0] recal_diff = counted > recal_val ? counted - recal_val : recal_val - counted;
  wire recal_err = recal_hit && recal_diff > recal_thr;
  wire [POS_W-1:0] next_position = is_force_cmd ? force_val :
                                   ref_event ? POS_RESET :
                                   recal_hit ? recal_val :
                                   referenced ? counted : position;
  wire next_referenced = (is_force_cmd || ref_event) ? 1'b1 :
                         (no_zero_err || home_ok) ? 1'b0 : referenced;

  wire [IRQ_W-1:0] irq_events;
  assign irq_events[IRQ_HOMED] = ref_event;
  assign irq_events[IRQ_NO_ZERO] = no_zero_err;
  assign irq_events[IRQ_REFUSED] = home_refused;
  assign irq_events[IRQ_RECAL_ERR] = recal_err;
  assign irq_events[IRQ_FAULT] = any_vis_fault;
  // set wins over the write-one clear
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~(we_irq_stat ? wdata[IRQ_W-1:0] : IRQ_RESET)) | irq_events;

  // ********************************
  // read mux
  // ********************************
  wire [31:0] next_rdata =
      addr == OFF_CTRL ? {20'h0, ctrl} :
      addr == OFF_STATUS ? {24'h0, 1'b0, state == AHFM_IDLE ? 1'b0 : 1'b1, hw_error_flag, axis_ok_flag,
                            axis_fault_flag, channel_error_bit, zero_seen, referenced} :
      addr == OFF_IRQ_STAT ? {27'h0, irq_stat} :
      addr == OFF_IRQ_MASK ? {27'h0, irq_mask} :
      addr == OFF_FORCE_VAL ? force_val :
      addr == OFF_RECAL_VAL ? recal_val :
      addr == OFF_RECAL_THR ? recal_thr :
      addr == OFF_AUTO_SPEED ? {16'h0, auto_speed} :
      addr == OFF_MANUAL_SPEED ? {16'h0, manual_speed} :
      addr == OFF_SCALE ? {24'h0, speed_scale_coeff} :
      addr == OFF_POSITION ? position :
      addr == OFF_FAULT_WORD ? {24'h0, channel_fault_word} :
      addr == OFF_SPEED ? {16'h0, speed_cmd} : 32'h0;

  // ********************************
  // flops
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      irq_mask <= IRQ_RESET;
      force_val <= POS_RESET;
      recal_val <= POS_RESET;
      recal_thr <= POS_RESET;
      auto_speed <= SPD_RESET;
      manual_speed <= SPD_RESET;
      speed_scale_coeff <= SCALE_RESET;
    end else if (ce && wr) begin
      if (we_ctrl) ctrl <= wdata[CTRL_W-1:0];
      if (addr == OFF_IRQ_MASK) irq_mask <= wdata[IRQ_W-1:0];
      if (addr == OFF_FORCE_VAL) force_val <= wdata;
      if (addr == OFF_RECAL_VAL) recal_val <= wdata;
      if (addr == OFF_RECAL_THR) recal_thr <= wdata;
      if (addr == OFF_AUTO_SPEED) auto_speed <= wdata[SPD_W-1:0];
      if (addr == OFF_MANUAL_SPEED) manual_speed <= wdata[SPD_W-1:0];
      if (addr == OFF_SCALE) speed_scale_coeff <= wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= AHFM_IDLE;
      homing_manual <= 1'b0;
      zero_seen <= 1'b0;
      cam_q <= 1'b0;
      det_q <= 1'b0;
      position <= POS_RESET;
      referenced <= 1'b0;
      irq_stat <= IRQ_RESET;
      rdata <= 32'h0;
      speed_cmd <= SPD_RESET;
      move_neg <= 1'b0;
      moving <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (home_ok) homing_manual <= cmd_manual;
      zero_seen <= home_ok ? 1'b0 : zero_seen | (field.cam && field.zero_marker);
      cam_q <= field.cam;
      det_q <= field.detector;
      position <= next_position;
      referenced <= next_referenced;
      irq_stat <= next_irq_stat;
      rdata <= rd ? next_rdata : 32'h0;
      speed_cmd <= any_raw_fault ? SPD_RESET : next_speed;
      move_neg <= next_move_neg;
      moving <= !any_raw_fault && next_speed != SPD_RESET;
    end
  end

  // masked faults neither raise the error bit nor reach the fault word
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_fault_word <= 8'h00;
      channel_error_bit <= 1'b0;
      axis_fault_flag <= 1'b0;
      axis_ok_flag <= 1'b0;
      hw_error_flag <= 1'b0;
      drive_enable <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      channel_fault_word <= vis_fault;
      channel_error_bit <= any_vis_fault || (|(irq_stat[IRQ_RECAL_ERR:IRQ_NO_ZERO]));
      axis_fault_flag <= any_raw_fault;
      axis_ok_flag <= !any_raw_fault;
      hw_error_flag <= any_raw_fault;
      drive_enable <= !any_raw_fault;
      irq <= |(next_irq_stat & irq_mask);
    end
  end
endmodule : ahfm_axis
`default_nettype wire

/* File: tb/ahfm_axis_properties.sv */
/* port checker for ahfm_axis, bound below.
 assumes ce high while checks matter and one clock. */
`timescale 1ns/1ps
`default_nettype none
module ahfm_axis_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ahfm_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire ahfm_pkg::ahfm_field_t field,
  input wire ahfm_pkg::ahfm_mfault_t mfault,
  input wire logic [3:0] other_fault,
  input wire logic [ahfm_pkg::SPD_W-1:0] speed_cmd,
  input wire logic move_neg,
  input wire logic moving,
  input wire logic drive_enable,
  input wire logic referenced,
  input wire logic channel_error_bit,
  input wire logic axis_fault_flag,
  input wire logic axis_ok_flag,
  input wire logic hw_error_flag,
  input wire logic irq
);
  import ahfm_pkg::*;
  // ****
  // checks
  // ****
  wire logic flt = (|mfault) || (|other_fault);
  wire logic frc = wr && addr == OFF_CMD && (wdata[4:0] == CMD_AUTO_FORCE || wdata[4:0] == CMD_MANUAL_FORCE);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_fault_drive_off: assert property (ce && flt && !$past(rst) |=> !drive_enable)
    else $error("drive enabled during fault");
  a_fault_stops_axis: assert property (ce && flt && !$past(rst) |=> speed_cmd == '0 && !moving)
    else $error("axis moves during fault");
  a_raw_fault_flags: assert property (ce && flt && !$past(rst) |=> axis_fault_flag && hw_error_flag && !axis_ok_flag)
    else $error("fault flags ignore raw fault");
  a_clear_ok_flags: assert property (ce && !flt && !$past(rst) ##1 ce && !flt |=> axis_ok_flag && !axis_fault_flag)
    else $error("ok flag missing without fault");
  a_moving_speed_pair: assert property (moving == (speed_cmd != '0))
    else $error("moving disagrees with speed");
  a_reset_unref: assert property ($past(rst) |-> !referenced && speed_cmd == '0)
    else $error("referenced right after reset");
  a_read_data_stands: assert property (ce && !rd |=> rdata == '0)
    else $error("read data outside its cycle");
  a_force_no_motion: assert property (ce && frc && !moving |=> !moving [*3])
    else $error("forced reference moved axis");
endmodule : ahfm_axis_properties
bind ahfm_axis ahfm_axis_properties u_props (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .field,
  .mfault, .other_fault, .speed_cmd, .move_neg, .moving, .drive_enable, .referenced, .channel_error_bit,
  .axis_fault_flag, .axis_ok_flag, .hw_error_flag, .irq);
`default_nettype wire

/* File: tb/ahfm_field_model.sv */
/* field side: encoder, cam, zero marker and detector of one axis.
 assumes the drive outputs of ahfm_axis; speed only gates motion. */
`timescale 1ns/1ps
`default_nettype none
module ahfm_field_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic moving,
  input wire logic move_neg,
  input wire logic tb_up,
  input wire logic det_req,
  input wire logic zero_en,
  input wire logic signed [31:0] cam_lo,
  input wire logic signed [31:0] cam_hi,
  input wire logic signed [31:0] zero_at,
  output var ahfm_pkg::ahfm_field_t field
);
  import ahfm_pkg::*;
  // ****
  // motion
  // ****
  logic signed [31:0] pos;
  logic [1:0] ph;
  logic up, dn, det;
  // one count every fourth cycle, so the axis can react before leaving a cam
  wire logic st = moving && ph == 2'd3;
  always_ff @(posedge clk) begin
    ph <= rst ? 2'd0 : ph + 2'd1;
    up <= !rst && (moving ? st && !move_neg : tb_up);
    dn <= !rst && st && move_neg;
    det <= !rst && det_req;
    if (rst) pos <= '0;
    else if (st || tb_up) pos <= (st && move_neg) ? pos - 1 : pos + 1;
  end
  assign field = '{cam: pos >= cam_lo && pos <= cam_hi, zero_marker: zero_en && pos == zero_at,
    detector: det, enc_up: up, enc_down: dn};
endmodule : ahfm_field_model
`default_nettype wire

/* File: tb/tb_ahfm_axis.sv */
/* self-checking bench for ahfm_axis with the field model.
 assumes the register map and command codes of ahfm_pkg. */
`timescale 1ns/1ps
`default_nettype none
module tb_ahfm_axis;
  import ahfm_pkg::*;
  // ****
  // bench
  // ****
  logic clk, rst, ce, wr, rd, tb_up, det_req, zero_en;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, d, v;
  logic signed [31:0] cam_lo, cam_hi, zero_at;
  ahfm_field_t field;
  ahfm_mfault_t mfault;
  logic [3:0] other_fault;
  logic [SPD_W-1:0] speed_cmd;
  logic move_neg, moving, drive_enable, referenced, channel_error_bit, axis_fault_flag, axis_ok_flag;
  logic hw_error_flag, irq;
  integer seed, err_count, compares, cyc, n, k;
  logic [11:0] hc [7] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h018, 12'h004, 12'h005};
  ahfm_axis dut (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .field, .mfault, .other_fault,
    .speed_cmd, .move_neg, .moving, .drive_enable, .referenced, .channel_error_bit, .axis_fault_flag,
    .axis_ok_flag, .hw_error_flag, .irq);
  ahfm_field_model fm (.clk, .rst, .moving, .move_neg, .tb_up, .det_req, .zero_en, .cam_lo, .cam_hi,
    .zero_at, .field);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic wreg(input logic [7:0] a, input logic [31:0] x);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] x);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 x = rdata;
    @(posedge clk);
  endtask : rreg
  task automatic bump();
    tb_up <= 1'b1;
    @(posedge clk);
    tb_up <= 1'b0;
    @(posedge clk);
  endtask : bump
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // expected speed is base times scale over 128; slow phase is an eighth
  task automatic home(input logic [11:0] cv, input logic [7:0] sc, input logic ok);
    logic [15:0] f;
    f = 16'h0100 | 16'($random(seed) & 16'h1fff);
    wreg(OFF_SCALE, 32'(sc));
    wreg(cv[3] ? OFF_MANUAL_SPEED : OFF_AUTO_SPEED, 32'(f));
    f = 16'((32'(f) * sc) >> 7);
    cam_lo <= cv[0] ? fm.pos - 40 : fm.pos + 20;
    cam_hi <= cv[0] ? fm.pos - 20 : fm.pos + 40;
    zero_at <= cv[0] ? fm.pos - 30 : fm.pos + 30;
    zero_en <= ok;
    wreg(OFF_CTRL, 32'(cv));
    wreg(OFF_CMD, 32'(cv[3] ? CMD_MANUAL_HOME : CMD_AUTO_HOME));
    n = 0;
    while (!moving && n < 20) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    chk32(32'(speed_cmd), 32'(f));
    chk1(move_neg, cv[0]);
    while (!field.cam && n < 300) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    repeat (3) @(posedge clk);
    #1 chk32(32'(speed_cmd), 32'((cv[1] || cv[0]) ? f >> 3 : f));
    chk1(move_neg, cv[0] ^ cv[1]);
    while (moving && n < 900) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    chk1(moving, 1'b0);
    chk1(referenced, ok);
    rreg(OFF_IRQ_STAT, d);
    chk32(d & 32'h3, ok ? 32'h1 : 32'h2);
    chk1(irq, 1'b1);
    wreg(OFF_IRQ_STAT, 32'h1f);
    #1 chk1(irq, 1'b0);
  endtask : home
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count = err_count + 1;
      end_sim();
    end
  end
  initial begin
    seed = 32'hf4e81fe2;
    {err_count, compares, cyc} = '0;
    {wr, rd, tb_up, det_req, zero_en, addr, wdata, mfault, other_fault, zero_at} = '0;
    cam_lo = 32'sh7fff_0000;
    cam_hi = 32'sh7fff_0000;
    ce = 1'b1;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk1(referenced, 1'b0);
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    wreg(OFF_SCALE, 32'h11);
    ce <= 1'b1;
    rreg(OFF_SCALE, d);
    chk32(d, 32'(SCALE_RESET));
    rreg(8'h3c, d);
    chk32(d, 32'h0);
    bump();
    rreg(OFF_POSITION, d);
    chk32(d, 32'(POS_RESET));
    $display("reset test done");
    for (k = 0; k < 9; k++) begin
      wreg(OFF_CTRL, k == 8 ? 32'hf00 : (32'(k[0]) << (8 + k[2:1])));
      v = $random(seed) & 3;
      if (k == 8) other_fault <= 4'h1 << v[1:0];
      else mfault <= 4'h1 << k[2:1];
      repeat (3) @(posedge clk);
      #1 chk1(axis_fault_flag && hw_error_flag && !axis_ok_flag, 1'b1);
      chk1(drive_enable, 1'b0);
      chk1(channel_error_bit, k == 8 || !k[0]);
      rreg(OFF_FAULT_WORD, d);
      chk32(d, k == 8 ? 32'h1 << v[1:0] : (k[0] ? 32'h0 : 32'h10 << k[2:1]));
      {mfault, other_fault} <= '0;
    end
    wreg(OFF_IRQ_STAT, 32'h1f);
    wreg(OFF_IRQ_MASK, 32'h1f);
    $display("fault mask test done");
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      wreg(OFF_CTRL, k < 2 ? 32'h0 : 32'h20);
      wreg(OFF_FORCE_VAL, v);
      wreg(OFF_CMD, 32'(k[0] ? CMD_MANUAL_FORCE : CMD_AUTO_FORCE));
      #1 chk1(referenced, 1'b1);
      if (k < 2) begin
        bump();
        rreg(OFF_POSITION, d);
        chk32(d, v + 1);
      end else begin
        wreg(OFF_RECAL_THR, k == 2 ? 32'h3 : 32'ha);
        wreg(OFF_RECAL_VAL, v + 5);
        wreg(OFF_IRQ_STAT, 32'h1f);
        det_req <= 1'b1;
        @(posedge clk);
        det_req <= 1'b0;
        repeat (3) @(posedge clk);
        rreg(OFF_POSITION, d);
        chk32(d, v + 5);
        rreg(OFF_IRQ_STAT, d);
        chk1(d[IRQ_RECAL_ERR], k == 2);
      end
    end
    wreg(OFF_IRQ_STAT, 32'h1f);
    $display("reference test done");
    for (k = 0; k < 7; k++) home(hc[k], k == 4 ? 8'h40 : 8'h80, k != 6);
    $display("homing test done");
    wreg(OFF_CTRL, 32'h12);
    wreg(OFF_CMD, 32'(CMD_AUTO_HOME));
    repeat (2) @(posedge clk);
    #1 chk1(moving, 1'b0);
    rreg(OFF_IRQ_STAT, d);
    chk1(d[IRQ_REFUSED], 1'b1);
    $display("rollover test done");
    // far cam keeps the axis approaching; stop command, then a drive fault, cut it short
    cam_lo <= fm.pos + 5000;
    cam_hi <= fm.pos + 5000;
    wreg(OFF_CTRL, 32'h0);
    for (k = 0; k < 2; k++) begin
      wreg(OFF_IRQ_STAT, 32'h1f);
      wreg(OFF_CMD, 32'(CMD_AUTO_HOME));
      wreg(OFF_CMD, 32'(CMD_AUTO_HOME));
      rreg(OFF_STATUS, d);
      chk32(d & 32'h41, 32'h40);
      chk1(moving, 1'b1);
      if (k == 0) wreg(OFF_CMD, 32'(CMD_STOP));
      else mfault <= 4'h8;
      repeat (2) @(posedge clk);
      #1 chk1(moving, 1'b0);
      chk1(drive_enable, k == 0);
      rreg(OFF_IRQ_STAT, d);
      chk32(d & 32'h14, k == 0 ? 32'h4 : 32'h14);
      rreg(OFF_SPEED, d);
      chk32(d, 32'h0);
      mfault <= '0;
    end
    $display("abort test done");
    end_sim();
  end
endmodule : tb_ahfm_axis
`default_nettype wire
